//--- src/rmc_config_cmd.v
// set-up command interpreter with parameter block and wishbone view
//
// Overview of operation
// - host sends bytes 0x01..0x7f to enter set-up; device echoes them back.
// - in set-up mode a 0x53 byte goes to the host every second.
// - parameter commands are only honoured while in set-up mode.
// - exit command leaves set-up silently and stops the heartbeat.
// - identity command returns ten characters: name then firmware version.
// - restore command reloads factory parameters, no reply.
// - read command returns the current 32-byte parameter block.
// - a 32-byte block starting with 0xfe replaces all parameters.
// - second byte bit 7 picks eight- or nine-bit character format.
// - second byte bits 6..5 pick none/mark, odd, even or space check.
// - second byte bits 2..0 pick host rate; default 9600; bits 4..3 zero.
// - bytes 3-4 hold group identifier, byte 5 the station identifier.
// - bytes 8..10 hold frequency in kHz, most significant first.
// - byte 11 bits 2..0 pick output power from 5 to 27 dBm.
// - mode 00 reaches the whole group and allows long payloads.
// - mode 01 takes a destination byte; receiver sees sender station first.
// - mode 10 data carries its own route; only last hop outputs payload.
// - mode 11 uses the stored route, up to 14 forwards, 127-byte payloads.
// - byte 13 counts the valid route bytes; the rest is ignored.
// - marker 0xff opens group and station; later bytes add stations.
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"
module rmc_config_cmd #(
  parameter HEARTBEAT_CYCLES = `RMC_HEARTBEAT_CYCLES,
  parameter [79:0] IDENT_STRING = `RMC_IDENT_STRING // arbitrary value
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  output reg tx_valid_o,
  output reg [7:0] tx_data_o,
  input wire tx_ready_i,
  output reg setup_mode_o
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ECHO = 4'b0010;
  localparam [3:0] ST_IDENT = 4'b0100;
  localparam [3:0] ST_PARAM = 4'b1000;

  function [7:0] default_byte;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: default_byte = `RMC_PARAM_START;
        `RMC_IDX_SERIAL: default_byte = `RMC_DEF_SERIAL;
        `RMC_IDX_GROUP_HI: default_byte = `RMC_DEF_GROUP_HI;
        `RMC_IDX_GROUP_LO: default_byte = `RMC_DEF_GROUP_LO;
        `RMC_IDX_STATION: default_byte = `RMC_DEF_STATION;
        `RMC_IDX_RF_RATE: default_byte = `RMC_DEF_RF_RATE;
        `RMC_IDX_FREQ_HI: default_byte = `RMC_DEF_FREQ_HI;
        `RMC_IDX_FREQ_MID: default_byte = `RMC_DEF_FREQ_MID;
        `RMC_IDX_FREQ_LO: default_byte = `RMC_DEF_FREQ_LO;
        `RMC_IDX_RADIO: default_byte = `RMC_DEF_RADIO;
        default: default_byte = 8'h00;
      endcase
    end
  endfunction

  function [7:0] ident_byte;
    input [6:0] idx;
    reg [79:0] sh;
    begin
      sh = IDENT_STRING << (8 * idx);
      ident_byte = sh[79:72];
    end
  endfunction

  reg [7:0] param_q [0:31];
  reg [7:0] shadow_q [0:31];
  reg [55:0] hist_q;
  reg [6:0] entry_cnt_q;
  reg [4:0] wr_cnt_q;
  reg wr_busy_q;
  reg pend_echo_q;
  reg pend_ident_q;
  reg pend_read_q;
  reg hb_pend_q;
  reg [31:0] hb_cnt_q;
  reg [3:0] state_q;
  reg [6:0] idx_q;
  reg [4:0] hop_sel_q;
  wire [55:0] hist_d;
  wire exit_hit;
  wire cmd_hit;
  wire tx_take;
  wire tx_free;
  wire [8*`RMC_ROUTE_BYTES-1:0] route_flat;
  wire [4:0] hop_count;
  wire [15:0] hop_group;
  wire [7:0] hop_station;
  wire hop_valid;
  wire wb_req;
  wire [1:0] mode;
  wire route_long;
  integer k;

  assign hist_d = {hist_q[47:0], rx_data_i};
  assign exit_hit = hist_d[39:0] == `RMC_EXIT_SEQ;
  assign cmd_hit = hist_d[55:8] == `RMC_CMD_PREFIX;
  assign tx_take = tx_valid_o & tx_ready_i;
  assign tx_free = ~tx_valid_o | tx_ready_i;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign mode = param_q[`RMC_IDX_RADIO][`RMC_MODE_HI:`RMC_MODE_LO];
  assign route_long = hop_count > `RMC_MAX_HOPS;

  genvar g;
  generate
    for (g = 0; g < `RMC_ROUTE_BYTES; g = g + 1) begin : g_route
      assign route_flat[8*g +: 8] = param_q[`RMC_IDX_ROUTE0 + g];
    end
  endgenerate

  rmc_route_walk #(
    .NBYTES(`RMC_ROUTE_BYTES)
  ) u_walk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .route_i(route_flat),
    .len_i(param_q[`RMC_IDX_ROUTE_LEN]),
    .sel_i(hop_sel_q),
    .hop_count_o(hop_count),
    .hop_group_o(hop_group),
    .hop_station_o(hop_station),
    .hop_valid_o(hop_valid)
  );

  // command parser, parameter store and heartbeat
  always @(posedge clk_i) begin
    if (rst_i) begin
      hist_q <= 56'h0;
      entry_cnt_q <= 7'h00;
      wr_cnt_q <= 5'h00;
      wr_busy_q <= 1'b0;
      pend_echo_q <= 1'b0;
      pend_ident_q <= 1'b0;
      pend_read_q <= 1'b0;
      setup_mode_o <= 1'b0;
      hb_cnt_q <= 32'h0;
      hb_pend_q <= 1'b0;
      for (k = 0; k < 32; k = k + 1) begin
        param_q[k] <= default_byte(k[4:0]);
        shadow_q[k] <= 8'h00;
      end
    end else begin
      // clear before set: a wrap in an idle cycle must not be swallowed
      if (state_q == ST_IDLE && tx_free && !pend_echo_q && !pend_ident_q && !pend_read_q) begin
        hb_pend_q <= 1'b0;
      end
      if (setup_mode_o) begin
        if (hb_cnt_q == HEARTBEAT_CYCLES - 1) begin
          hb_cnt_q <= 32'h0;
          hb_pend_q <= 1'b1;
        end else begin
          hb_cnt_q <= hb_cnt_q + 32'h1;
        end
      end
      if (state_q == ST_IDLE && tx_free) begin
        pend_echo_q <= 1'b0;
        if (!pend_echo_q) begin
          pend_ident_q <= 1'b0;
          if (!pend_ident_q) begin
            pend_read_q <= 1'b0;
          end
        end
      end
      if (rx_valid_i) begin
        hist_q <= hist_d;
        if (!setup_mode_o) begin
          // entry sequence must arrive unbroken; a stray 0x01 restarts it
          if (rx_data_i == {1'b0, entry_cnt_q + 7'h01}) begin
            if (entry_cnt_q + 7'h01 == `RMC_ENTRY_LAST) begin
              entry_cnt_q <= 7'h00;
              setup_mode_o <= 1'b1;
              hb_cnt_q <= 32'h0;
              pend_echo_q <= 1'b1;
            end else begin
              entry_cnt_q <= entry_cnt_q + 7'h01;
            end
          end else if (rx_data_i == 8'h01) begin
            entry_cnt_q <= 7'h01;
          end else begin
            entry_cnt_q <= 7'h00;
          end
        end else if (wr_busy_q) begin
          // command bytes inside a block are data, not commands
          shadow_q[wr_cnt_q] <= rx_data_i;
          wr_cnt_q <= wr_cnt_q + 5'h01;
          if (wr_cnt_q == `RMC_PARAM_LAST) begin
            wr_busy_q <= 1'b0;
            hist_q <= 56'h0;
            for (k = 0; k < 31; k = k + 1) begin
              param_q[k] <= shadow_q[k];
            end
            param_q[31] <= rx_data_i;
          end
        end else if (exit_hit) begin
          setup_mode_o <= 1'b0;
          hb_pend_q <= 1'b0;
          hb_cnt_q <= 32'h0;
          hist_q <= 56'h0;
        end else if (cmd_hit && rx_data_i == `RMC_CMD_IDENT) begin
          pend_ident_q <= 1'b1;
          hist_q <= 56'h0;
        end else if (cmd_hit && rx_data_i == `RMC_CMD_RESTORE) begin
          for (k = 0; k < 32; k = k + 1) begin
            param_q[k] <= default_byte(k[4:0]);
          end
          hist_q <= 56'h0;
        end else if (cmd_hit && rx_data_i == `RMC_CMD_READ) begin
          pend_read_q <= 1'b1;
          hist_q <= 56'h0;
        end else if (rx_data_i == `RMC_PARAM_START) begin
          shadow_q[0] <= rx_data_i;
          wr_cnt_q <= 5'h01;
          wr_busy_q <= 1'b1;
        end
        // anything else only shifts the history and is dropped
      end
    end
  end

  // reply sequencer; a request waits while another reply is under way
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      idx_q <= 7'h00;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else begin
      if (tx_take) begin
        tx_valid_o <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          idx_q <= 7'h00;
          if (tx_free) begin
            if (pend_echo_q) begin
              state_q <= ST_ECHO;
            end else if (pend_ident_q) begin
              state_q <= ST_IDENT;
            end else if (pend_read_q) begin
              state_q <= ST_PARAM;
            end else if (hb_pend_q && setup_mode_o) begin
              tx_valid_o <= 1'b1;
              tx_data_o <= `RMC_HEARTBEAT_BYTE;
            end
          end
        end
        ST_ECHO: begin
          if (tx_free) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= {1'b0, idx_q + 7'h01};
            idx_q <= idx_q + 7'h01;
            if (idx_q + 7'h01 == `RMC_ENTRY_LAST) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_IDENT: begin
          if (tx_free) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= ident_byte(idx_q);
            idx_q <= idx_q + 7'h01;
            if (idx_q == `RMC_IDENT_LAST) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_PARAM: begin
          if (tx_free) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= param_q[idx_q[4:0]];
            idx_q <= idx_q + 7'h01;
            if (idx_q[4:0] == `RMC_PARAM_LAST) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // wishbone slave: one wait state, unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      hop_sel_q <= 5'h00;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        if (wb_we_i && wb_adr_i == `RMC_REG_HOP_SEL && wb_sel_i[0]) begin
          hop_sel_q <= wb_dat_i[4:0];
        end
        case (wb_adr_i)
          `RMC_REG_STATUS: begin
            wb_dat_o <= {28'h0, route_long, wr_busy_q, ~state_q[0], setup_mode_o};
          end
          `RMC_REG_SERIAL: begin
            wb_dat_o <= {18'h0, param_q[`RMC_IDX_SERIAL][`RMC_RATE_HI:`RMC_RATE_LO],
              param_q[`RMC_IDX_SERIAL][`RMC_CHECK_HI:`RMC_CHECK_LO],
              param_q[`RMC_IDX_SERIAL][`RMC_BIT_CHAR9],
              param_q[`RMC_IDX_SERIAL]};
          end
          `RMC_REG_ADDR: begin
            wb_dat_o <= {8'h0, param_q[`RMC_IDX_GROUP_HI], param_q[`RMC_IDX_GROUP_LO],
              param_q[`RMC_IDX_STATION]};
          end
          `RMC_REG_RADIO: begin
            // payload limit, destination prefix, inline route, stored route
            wb_dat_o <= {8'h0, (mode == `RMC_MODE_LONG) ? 8'h00 : `RMC_PAYLOAD_LIMIT,
              2'h0, mode == `RMC_MODE_STORED, mode == `RMC_MODE_ROUTE,
              mode == `RMC_MODE_DEST, 1'b0, mode,
              1'b0, param_q[`RMC_IDX_RADIO][`RMC_POWER_HI:`RMC_POWER_LO],
              1'b0, param_q[`RMC_IDX_RF_RATE][2:0]};
          end
          `RMC_REG_FREQ: begin
            wb_dat_o <= {8'h0, param_q[`RMC_IDX_FREQ_HI], param_q[`RMC_IDX_FREQ_MID],
              param_q[`RMC_IDX_FREQ_LO]};
          end
          `RMC_REG_HOP_SEL: begin
            wb_dat_o <= {19'h0, hop_count, 3'h0, hop_sel_q};
          end
          `RMC_REG_HOP: begin
            wb_dat_o <= {7'h0, hop_valid, hop_group, hop_station};
          end
          default: begin
            wb_dat_o <= 32'h0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- inc/rmc_consts.vh
// constants for the radio modem configuration command interpreter
`ifndef RMC_CONSTS_VH
`define RMC_CONSTS_VH

`define RMC_CLK_KHZ 100000
`define RMC_HEARTBEAT_MS 1000
`define RMC_HEARTBEAT_CYCLES (`RMC_HEARTBEAT_MS * `RMC_CLK_KHZ)

`define RMC_ENTRY_LAST 7'h7f
`define RMC_HEARTBEAT_BYTE 8'h53
`define RMC_EXIT_SEQ 40'hffffff55cc
`define RMC_CMD_PREFIX 48'hffffff55aabb
`define RMC_CMD_IDENT 8'hfd
`define RMC_CMD_RESTORE 8'hff
`define RMC_CMD_READ 8'hfe
`define RMC_PARAM_START 8'hfe
`define RMC_PARAM_LAST 5'h1f
`define RMC_IDENT_LAST 7'h09
`define RMC_IDENT_STRING 80'h41424344454656303030
`define RMC_ROUTE_MARK 8'hff
`define RMC_ROUTE_BYTES 19
`define RMC_MAX_HOPS 5'h0e
`define RMC_PAYLOAD_LIMIT 8'h7f

`define RMC_IDX_SERIAL 5'h01
`define RMC_IDX_GROUP_HI 5'h02
`define RMC_IDX_GROUP_LO 5'h03
`define RMC_IDX_STATION 5'h04
`define RMC_IDX_RES6 5'h05
`define RMC_IDX_RF_RATE 5'h06
`define RMC_IDX_FREQ_HI 5'h07
`define RMC_IDX_FREQ_MID 5'h08
`define RMC_IDX_FREQ_LO 5'h09
`define RMC_IDX_RADIO 5'h0a
`define RMC_IDX_RES12 5'h0b
`define RMC_IDX_ROUTE_LEN 5'h0c
`define RMC_IDX_ROUTE0 13

`define RMC_BIT_CHAR9 7
`define RMC_CHECK_HI 6
`define RMC_CHECK_LO 5
`define RMC_RATE_HI 2
`define RMC_RATE_LO 0
`define RMC_POWER_HI 2
`define RMC_POWER_LO 0
`define RMC_MODE_HI 7
`define RMC_MODE_LO 6

`define RMC_MODE_LONG 2'h0
`define RMC_MODE_DEST 2'h1
`define RMC_MODE_ROUTE 2'h2
`define RMC_MODE_STORED 2'h3

`define RMC_DEF_SERIAL 8'h03
`define RMC_DEF_GROUP_HI 8'h00
`define RMC_DEF_GROUP_LO 8'h00
`define RMC_DEF_STATION 8'h00
`define RMC_DEF_RF_RATE 8'h03
`define RMC_DEF_FREQ_HI 8'h0e
`define RMC_DEF_FREQ_MID 8'h1d
`define RMC_DEF_FREQ_LO 8'h48
`define RMC_DEF_RADIO 8'h07

`define RMC_REG_STATUS 8'h00
`define RMC_REG_SERIAL 8'h04
`define RMC_REG_ADDR 8'h08
`define RMC_REG_RADIO 8'h0c
`define RMC_REG_FREQ 8'h10
`define RMC_REG_HOP_SEL 8'h14
`define RMC_REG_HOP 8'h18

`endif

//--- src/rmc_route_walk.v
// walks the stored route and returns one selected hop
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"
module rmc_route_walk #(
  parameter NBYTES = `RMC_ROUTE_BYTES
) (
  input wire clk_i,
  input wire rst_i,
  input wire [8*NBYTES-1:0] route_i,
  input wire [7:0] len_i,
  input wire [4:0] sel_i,
  output reg [4:0] hop_count_o,
  output reg [15:0] hop_group_o,
  output reg [7:0] hop_station_o,
  output reg hop_valid_o
);
  reg [1:0] phase;
  reg [15:0] grp;
  reg [4:0] cnt;
  reg [7:0] b;
  reg [15:0] sel_grp;
  reg [7:0] sel_sta;
  reg sel_ok;
  integer i;

  always @* begin
    phase = 2'h0;
    grp = 16'h0000;
    cnt = 5'h00;
    b = 8'h00;
    sel_grp = 16'h0000;
    sel_sta = 8'h00;
    sel_ok = 1'b0;
    for (i = 0; i < NBYTES; i = i + 1) begin
      b = route_i[8*i +: 8];
      if (i < len_i) begin
        case (phase)
          2'h0: begin
            if (b == `RMC_ROUTE_MARK) begin
              phase = 2'h1;
            end else begin
              if (cnt == sel_i) begin
                sel_grp = grp;
                sel_sta = b;
                sel_ok = 1'b1;
              end
              cnt = cnt + 5'h01;
            end
          end
          2'h1: begin
            grp[15:8] = b;
            phase = 2'h2;
          end
          2'h2: begin
            grp[7:0] = b;
            phase = 2'h3;
          end
          default: begin
            if (cnt == sel_i) begin
              sel_grp = grp;
              sel_sta = b;
              sel_ok = 1'b1;
            end
            cnt = cnt + 5'h01;
            phase = 2'h0;
          end
        endcase
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      hop_count_o <= 5'h00;
      hop_group_o <= 16'h0000;
      hop_station_o <= 8'h00;
      hop_valid_o <= 1'b0;
    end else begin
      hop_count_o <= cnt;
      hop_group_o <= sel_grp;
      hop_station_o <= sel_sta;
      hop_valid_o <= sel_ok;
    end
  end
endmodule
`default_nettype wire

//--- tb/rmc_config_cmd_assertions.sv
// port assertions for the set-up command interpreter
`timescale 1ns/1ps
`default_nettype none
module rmc_config_cmd_assertions #(
  parameter HEARTBEAT_CYCLES = 1000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic setup_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack late");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdata_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved");
  a_tx_byte_holds: assert property ((tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte dropped");
  a_tx_only_setup: assert property ($rose(tx_valid_o) |-> setup_mode_o)
    else $error("reply outside set-up");
  a_entry_last_byte: assert property (
    $rose(setup_mode_o) |-> $past(rx_valid_i) && $past(rx_data_i) == 8'h7f)
    else $error("set-up without entry");
  a_echo_first: assert property ($rose(setup_mode_o) |-> ##2 (tx_valid_o && tx_data_o == 8'h01))
    else $error("echo late");
  a_exit_leaves: assert property (
    (setup_mode_o && rx_valid_i && rx_data_i == 8'hff) ##1 (rx_valid_i && rx_data_i == 8'hff)
    ##1 (rx_valid_i && rx_data_i == 8'hff) ##1 (rx_valid_i && rx_data_i == 8'h55)
    ##1 (rx_valid_i && rx_data_i == 8'hcc) |=> !setup_mode_o)
    else $error("exit ignored");
endmodule
bind rmc_config_cmd rmc_config_cmd_assertions #(.HEARTBEAT_CYCLES(HEARTBEAT_CYCLES)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
  .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
  .setup_mode_o(setup_mode_o));
`default_nettype wire

//--- tb/rmc_host_model.sv
// host partner on the serial side: sends bytes, collects replies
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model (
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic slow = 1'b0;
  logic [1:0] cnt = 2'd0;
  logic [7:0] got[$];
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b1;
  end
  // stalled host takes one byte in four so replies must wait
  always @(posedge clk_i) begin
    cnt <= cnt + 2'd1;
    tx_ready_o <= !slow || cnt == 2'd3;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end
  // idle data shows the inverse of the last byte, never a stale copy
  task send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= b[i];
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~b[b.size() - 1];
  endtask
endmodule
`default_nettype wire

//--- tb/rmc_config_cmd_tb_top.sv
// self-checking bench for the set-up command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "rmc_consts.vh"
module rmc_config_cmd_tb_top;
  localparam int HB = 1000;
  localparam logic [79:0] ID = 80'h4b4c4d4e4f5056303032; // arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd, dat;
  logic ack, rxv, txv, txr, setup;
  logic [7:0] rxd, txd;
  logic [7:0] blk[$], eq[$];
  int n_fail = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  rmc_config_cmd #(.HEARTBEAT_CYCLES(HB), .IDENT_STRING(ID)) dut_u (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .rx_valid_i(rxv),
    .rx_data_i(rxd), .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr),
    .setup_mode_o(setup));
  rmc_host_model host_u (.clk_i(clk_i), .rx_valid_o(rxv), .rx_data_o(rxd), .tx_valid_i(txv),
    .tx_data_i(txd), .tx_ready_o(txr));
  task chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
    checks++;
    if (seen !== expv) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // this wait ends when ack is seen; only the watchdog ends it if no ack comes
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // a heartbeat may land before or after a reply, so stray 0x53 bytes are skipped
  task reply(input string what, input int n);
    int t;
    int i;
    t = 0;
    i = 0;
    while (host_u.got.size() < n && t < 3000) begin
      @(negedge clk_i);
      t++;
    end
    repeat (40) @(negedge clk_i);
    foreach (host_u.got[k]) begin
      if (host_u.got[k] === eq[i]) i++;
      else if (host_u.got[k] !== `RMC_HEARTBEAT_BYTE) chk(what, host_u.got[k], eq[i]);
    end
    chk(what, i, eq.size());
    host_u.got.delete();
  endtask
  task cmd(input logic [7:0] c);
    host_u.send('{8'hff, 8'hff, 8'hff, 8'h55, 8'haa, 8'hbb, c});
  endtask
  task t_entry();
    cmd(`RMC_CMD_READ);
    cmd(`RMC_CMD_IDENT);
    eq.delete();
    reply("early reply", 0);
    for (int b = 1; b < 128; b++) eq.push_back(8'(b));
    host_u.slow = 1'b1;
    host_u.send(eq);
    reply("echo", 127);
    chk("setup", setup, 1'b1);
    host_u.slow = 1'b0;
    eq.delete();
    for (int i = 9; i >= 0; i--) eq.push_back(ID[8*i +: 8]);
    cmd(`RMC_CMD_IDENT);
    reply("ident", 10);
  endtask
  task t_write();
    blk = '{8'hfe, 8'he2, 8'ha5, 8'h5a, 8'h3c, 8'h00, 8'h05, 8'h0e, 8'h1b, 8'h54, 8'hc6,
      8'h00, 8'h05, 8'hff, 8'h12, 8'h34, 8'h55, 8'h11, 8'h22};
    while (blk.size() < 32) blk.push_back(8'h44);
    host_u.send(blk);
    wb(0, `RMC_REG_SERIAL, 0);
    chk("serial", rd[13:0], {3'd2, 2'b11, 1'b1, 8'he2});
    wb(0, `RMC_REG_ADDR, 0);
    chk("addr", rd[23:0], 24'ha55a3c);
    wb(0, `RMC_REG_FREQ, 0);
    chk("freq", rd[23:0], 24'h0e1b54);
    wb(0, `RMC_REG_RADIO, 0);
    chk("radio", {rd[13], rd[9:8], rd[6:4], rd[2:0]}, {1'b1, 2'b11, 3'd6, 3'd5});
    wb(1, `RMC_REG_HOP_SEL, 32'h1);
    wb(0, `RMC_REG_HOP_SEL, 0);
    chk("hop count", rd[12:8], 5'd2);
    wb(0, `RMC_REG_HOP, 0);
    chk("hop", rd[24:0], {1'b1, 16'h1234, 8'h11});
    wb(0, 8'hfc, 0);
    chk("unmapped", rd, 0);
    eq = blk;
    cmd(`RMC_CMD_READ);
    reply("read back", 32);
    for (int m = 0; m < 4; m++) begin
      blk[10] = {m[1:0], 6'h06};
      host_u.send(blk);
      wb(0, `RMC_REG_RADIO, 0);
      chk("mode", rd[13:11], (m == 0) ? 3'b000 : 3'b001 << (m - 1));
      chk("limit", rd[23:16], (m == 0) ? 8'h00 : 8'h7f);
    end
    blk[12] = 8'h13;
    host_u.send(blk);
    wb(0, `RMC_REG_STATUS, 0);
    chk("long route", rd[3:0], 4'h9);
  endtask
  task t_restore();
    cmd(`RMC_CMD_RESTORE);
    eq = '{8'hfe, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h0e, 8'h1d, 8'h48, 8'h07};
    while (eq.size() < 32) eq.push_back(8'h00);
    cmd(`RMC_CMD_READ);
    reply("restored", 32);
    cmd(8'h01);
    host_u.send('{8'h12, 8'h34});
    eq.delete();
    reply("unknown", 0);
    wb(0, `RMC_REG_FREQ, 0);
    chk("freq kept", rd[23:0], 24'h0e1d48);
  endtask
  task t_beat_exit();
    int t;
    host_u.got.delete();
    for (int n = 1; n < 3; n++) begin
      t = 0;
      while (host_u.got.size() < n && t < 2 * HB) begin
        @(negedge clk_i);
        t++;
      end
    end
    chk("beat", host_u.got[0], `RMC_HEARTBEAT_BYTE);
    chk("beat gap", t, HB);
    host_u.send('{8'hff, 8'hff, 8'hff, 8'h55, 8'hcc});
    @(negedge clk_i);
    chk("exit", setup, 1'b0);
    host_u.got.delete();
    repeat (2 * HB + 50) @(posedge clk_i);
    chk("silent", host_u.got.size(), 0);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_entry();
    $display("test entry done");
    t_write();
    $display("test write done");
    t_restore();
    $display("test restore done");
    t_beat_exit();
    $display("test heartbeat done");
    results();
  end
endmodule
`default_nettype wire
